// ### core/trace_capture_params.svh
// constants of the bus trace capture block: offsets, reset values, counts
// assumes 32-bit register port with byte addresses, one clock at 125 MHz
`ifndef TRACE_CAPTURE_PARAMS_SVH
`define TRACE_CAPTURE_PARAMS_SVH
`define TRC_DEPTH 32768
`define TRC_ADDR_W 15
`define TRC_WORDS_PER_LINE 3
`define TRC_BYTES_PER_LINE 32'h0000_000C
`define TRC_POST_LINES 15'h4000
`define TRC_HB_SHIFT 8
// register byte offsets
`define REG_COMMAND 8'h00
`define REG_CONFIG 8'h04
`define REG_STATUS 8'h08
`define REG_TRIG_LINE 8'h0C
`define REG_LINE_COUNT 8'h10
`define REG_BYTES_PER_LINE 8'h14
`define REG_UPLOAD_LINE 8'h18
`define REG_UPLOAD_DATA 8'h1C
`define REG_TRIG_VAL_LO 8'h20
`define REG_TRIG_VAL_HI 8'h24
`define REG_TRIG_CARE_LO 8'h28
`define REG_TRIG_CARE_HI 8'h2C
`define REG_SQ_VAL_LO 8'h30
`define REG_SQ_VAL_HI 8'h34
`define REG_SQ_CARE_LO 8'h38
`define REG_SQ_CARE_HI 8'h3C
`define REG_OBSERVER 8'h40
// command bits
`define CMD_TRACE_RUN 0
`define CMD_TRACE_STOP 1
`define CMD_ANA_RUN 2
`define CMD_ANA_STOP 3
// config fields
`define CFG_HB_MODE 0
`define CFG_HB_LSB 16
`define CFG_HB_MSB 31
// status bits
`define STAT_STOPPED 0
`define STAT_TRIGGERED 1
// reset values
`define RST_WORD 32'h0000_0000
`define RST_CARE 32'h0000_0000
`endif

// ### core/trace_capture_pkg.sv
// types shared by the bus trace capture block
// assumes trace_capture_params.svh supplies the numeric constants
package trace_capture_pkg;
    // sampled pins of the observed bus, 48 bits
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0] cbe;
        logic frame, irdy, trdy, devsel, stop, idsel;
        logic perr, serr, req, gnt, lock, par;
    } bus_pins_type;

    // one captured line, 96 bits, uploaded as three words, word 0 lowest
    typedef struct packed {
        logic [38:0] spare;
        logic trigger_mark;
        logic continuity_flag;
        logic responder_locked_flag;
        logic initiator_locked_flag;
        logic responder_active_flag;
        logic initiator_active_flag;
        logic [2:0] bus_phase_code;
        bus_pins_type pins;
    } trace_line_type;

    typedef struct packed {
        logic [2:0] bus_phase_code;
        logic initiator_active_flag;
        logic responder_active_flag;
        logic initiator_locked_flag;
        logic responder_locked_flag;
    } observer_bits_type;

    typedef enum logic [1:0] {
        CAP_IDLE = 2'b00,
        CAP_PRE = 2'b01,
        CAP_POST = 2'b11,
        CAP_DONE = 2'b10
    } cap_state_type;
endpackage

// ### core/bus_trace_capture.sv
// trace capture of a bus analyzer: samples bus pins and observer bits into
// a line memory, tracks trigger line and line count, uploads over reg port.
// assumes bus pins arrive from outside (synchronised here) and observer bits
// come from logic on sys_clk.
//
// How it works
// RL1 - 32k lines, three words each on upload
// RL2 - every signal at fixed bit field
// RL3 - three-bit bus phase code per line
// RL4 - bit set while own initiator active
// RL5 - bit set while own responder active
// RL6 - bit set during own locked transaction
// RL7 - bit set while responder held locked
// RL8 - continuity bit zero after a skipped state
// RL9 - status bit0 stopped, bit1 triggered, rest zero
// RL10 - record trigger line and captured count
// RL11 - host reads index/count only when stopped
// RL12 - trace run enables qualified capture
// RL13 - trace stop keeps status and memory
// RL14 - analyzer run starts observer and capture
// RL15 - analyzer stop halts both, keeps contents
// RL16 - upload from start line, fixed line size
// RL17 - heartbeat: trigger on missing event timeout
// RL18 - trigger, qualifier use one/zero/dont-care compare
// RL19 - one sample per clock, stored when qualified
// RL20 - stop after TRC_POST_LINES + 1 lines past the trigger line
`include "trace_capture_params.svh"
module bus_trace_capture
    import trace_capture_pkg::*;
(
    input wire logic sys_clk, // 125 MHz clock, also sampling clock
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire bus_pins_type bus_pins, // observed bus pins, asynchronous
    input wire observer_bits_type observer_bits, // bus observer state
    output logic observer_run // protocol observer run enable
);
    localparam logic [14:0] ADDR_ONE = 15'h0001;
    localparam logic [14:0] ADDR_LAST = 15'h7FFF;
    localparam logic [1:0] WORD_LAST = 2'(`TRC_WORDS_PER_LINE - 1);

    bus_pins_type sync1_q, sync2_q, sync3_q, pins_q;
    logic [47:0] agree;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pins_q <= '0;
        end else begin
            sync1_q <= bus_pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pins_q <= (sync2_q & agree) | (pins_q & ~agree);
        end
    end
    // a pin change is accepted only once two late stages agree
    assign agree = ~(sync2_q ^ sync3_q);

    logic wr_cmd, hb_mode_q;
    logic [15:0] hb_timeout_q;
    logic [47:0] trig_val_q, trig_care_q, sq_val_q, sq_care_q;
    assign wr_cmd = reg_wr && reg_addr == `REG_COMMAND;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hb_mode_q <= 1'b0;
            hb_timeout_q <= '0;
            trig_val_q <= '0;
            trig_care_q <= '0;
            sq_val_q <= '0;
            sq_care_q <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `REG_CONFIG) begin
                hb_mode_q <= reg_wdata[`CFG_HB_MODE];
                hb_timeout_q <= reg_wdata[`CFG_HB_MSB:`CFG_HB_LSB];
            end else if (reg_addr == `REG_TRIG_VAL_LO) begin
                trig_val_q[31:0] <= reg_wdata;
            end else if (reg_addr == `REG_TRIG_VAL_HI) begin
                trig_val_q[47:32] <= reg_wdata[15:0];
            end else if (reg_addr == `REG_TRIG_CARE_LO) begin
                trig_care_q[31:0] <= reg_wdata;
            end else if (reg_addr == `REG_TRIG_CARE_HI) begin
                trig_care_q[47:32] <= reg_wdata[15:0];
            end else if (reg_addr == `REG_SQ_VAL_LO) begin
                sq_val_q[31:0] <= reg_wdata;
            end else if (reg_addr == `REG_SQ_VAL_HI) begin
                sq_val_q[47:32] <= reg_wdata[15:0];
            end else if (reg_addr == `REG_SQ_CARE_LO) begin
                sq_care_q[31:0] <= reg_wdata;
            end else if (reg_addr == `REG_SQ_CARE_HI) begin
                sq_care_q[47:32] <= reg_wdata[15:0];
            end
        end
    end

    // care bit 0 is dont-care; care bit 1 compares against value bit
    logic trig_hit, sq_hit;
    assign trig_hit = ((pins_q ^ trig_val_q) & trig_care_q) == '0; // [RL18]
    assign sq_hit = ((pins_q ^ sq_val_q) & sq_care_q) == '0; // [RL18]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            observer_run <= 1'b0;
        end else if (wr_cmd && reg_wdata[`CMD_ANA_STOP]) begin
            observer_run <= 1'b0; // [RL15]
        end else if (wr_cmd && reg_wdata[`CMD_ANA_RUN]) begin
            observer_run <= 1'b1; // [RL14]
        end
    end

    logic start_cmd, stop_cmd;
    assign start_cmd = wr_cmd && (reg_wdata[`CMD_TRACE_RUN] || reg_wdata[`CMD_ANA_RUN]); // [RL12] [RL14]
    assign stop_cmd = wr_cmd && (reg_wdata[`CMD_TRACE_STOP] || reg_wdata[`CMD_ANA_STOP]); // [RL13] [RL15]

    cap_state_type state_q, state_d;
    logic [14:0] wr_ptr_q, trig_line_q, post_cnt_q;
    logic [15:0] line_cnt_q;
    logic [23:0] hb_cnt_q;
    logic stopped_q, triggered_q, gap_q, fire, store, running;
    logic [23:0] hb_limit;
    // timeout counts in steps of 256 clocks, so a 16-bit value spans long gaps
    assign hb_limit = 24'(hb_timeout_q) << `TRC_HB_SHIFT;
    assign running = state_q == CAP_PRE || state_q == CAP_POST;
    // heartbeat: the pattern is the expected event, its absence fires
    assign fire = state_q == CAP_PRE
        && (hb_mode_q ? (!trig_hit && hb_cnt_q >= hb_limit) : trig_hit); // [RL17]
    assign store = running && (sq_hit || fire); // [RL19]

    // run while running is ignored so a repeated command cannot wipe a trace
    always_comb begin
        state_d = state_q;
        case (state_q)
            CAP_IDLE, CAP_DONE: begin
                if (start_cmd) begin
                    state_d = CAP_PRE;
                end
            end
            CAP_PRE: begin
                if (stop_cmd) begin
                    state_d = CAP_DONE;
                end else if (fire) begin
                    state_d = CAP_POST;
                end
            end
            CAP_POST: begin
                if (stop_cmd || (store && post_cnt_q == `TRC_POST_LINES)) begin
                    state_d = CAP_DONE; // [RL20]
                end
            end
            default: state_d = CAP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CAP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // both flags stand until a fresh run; a stop command while running sets stopped, and none clears either flag
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stopped_q <= 1'b0;
            triggered_q <= 1'b0;
        end else if (start_cmd && !running) begin
            stopped_q <= 1'b0;
            triggered_q <= 1'b0;
        end else begin
            if (running && state_d == CAP_DONE) begin
                stopped_q <= 1'b1; // [RL9] [RL20]
            end
            if (fire) begin
                triggered_q <= 1'b1; // [RL9]
            end
        end
    end

    // counts clocks since the last expected event
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hb_cnt_q <= '0;
        end else if (state_q != CAP_PRE || trig_hit) begin
            hb_cnt_q <= '0; // [RL17]
        end else if (hb_cnt_q != '1) begin
            hb_cnt_q <= hb_cnt_q + 24'h00_0001;
        end
    end

    // pre-trigger lines wrap round and overwrite the oldest ones
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
        end else if (start_cmd && !running) begin
            wr_ptr_q <= '0;
        end else if (store) begin
            wr_ptr_q <= wr_ptr_q + ADDR_ONE;
        end
    end

    // count saturates at depth, it never wraps with the pointer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_cnt_q <= '0;
        end else if (start_cmd && !running) begin
            line_cnt_q <= '0;
        end else if (store && line_cnt_q != 16'(`TRC_DEPTH)) begin
            line_cnt_q <= line_cnt_q + 16'h0001; // [RL10]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_line_q <= '0;
        end else if (start_cmd && !running) begin
            trig_line_q <= '0;
        end else if (store && fire) begin
            trig_line_q <= wr_ptr_q; // [RL10]
        end
    end

    // lines stored after the trigger decide when capture ends
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            post_cnt_q <= '0;
        end else if (start_cmd && !running) begin
            post_cnt_q <= '0;
        end else if (store && state_q == CAP_POST) begin
            post_cnt_q <= post_cnt_q + ADDR_ONE;
        end
    end

    // first line of a run has no predecessor, so it never shows a gap
    logic stored_any_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stored_any_q <= 1'b0;
        end else if (start_cmd && !running) begin
            stored_any_q <= 1'b0;
        end else if (store) begin
            stored_any_q <= 1'b1;
        end
    end

    // a skipped sample while running breaks continuity of the next stored one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 1'b0;
        end else if (start_cmd && !running) begin
            gap_q <= 1'b0;
        end else if (running) begin
            gap_q <= !store && stored_any_q; // [RL8]
        end
    end

    trace_line_type line_in;
    always_comb begin
        line_in = '0;
        line_in.pins = pins_q; // [RL2]
        line_in.bus_phase_code = observer_bits.bus_phase_code; // [RL3]
        line_in.initiator_active_flag = observer_bits.initiator_active_flag; // [RL4]
        line_in.responder_active_flag = observer_bits.responder_active_flag; // [RL5]
        line_in.initiator_locked_flag = observer_bits.initiator_locked_flag; // [RL6]
        line_in.responder_locked_flag = observer_bits.responder_locked_flag; // [RL7]
        line_in.continuity_flag = !gap_q; // [RL8]
        line_in.trigger_mark = fire;
    end

    trace_line_type mem [`TRC_DEPTH]; // [RL1]
    always_ff @(posedge sys_clk) begin
        if (store) begin
            mem[wr_ptr_q] <= line_in; // [RL19]
        end
    end

    // upload pointer: line address plus word within line
    logic [14:0] up_line_q;
    logic [1:0] up_word_q;
    logic up_rd;
    assign up_rd = reg_rd && reg_addr == `REG_UPLOAD_DATA;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_line_q <= '0;
            up_word_q <= '0;
        end else if (reg_wr && reg_addr == `REG_UPLOAD_LINE) begin
            up_line_q <= reg_wdata[`TRC_ADDR_W-1:0]; // [RL16]
            up_word_q <= '0;
        end else if (up_rd) begin
            if (up_word_q == WORD_LAST) begin
                up_word_q <= '0;
                up_line_q <= up_line_q == ADDR_LAST ? '0 : up_line_q + ADDR_ONE;
            end else begin
                up_word_q <= up_word_q + 2'b01; // [RL1]
            end
        end
    end

    trace_line_type up_line;
    logic [31:0] up_data;
    assign up_line = mem[up_line_q];
    always_comb begin
        case (up_word_q)
            2'd0: up_data = up_line[31:0];
            2'd1: up_data = up_line[63:32];
            default: up_data = up_line[95:64];
        endcase
    end

    // index and count are meaningful only once stopped; read is not blocked
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `RST_WORD;
        end else if (!reg_rd) begin
            reg_rdata <= `RST_WORD;
        end else if (reg_addr == `REG_STATUS) begin
            reg_rdata <= {30'h0, triggered_q, stopped_q}; // [RL9]
        end else if (reg_addr == `REG_TRIG_LINE) begin
            reg_rdata <= {17'h0, trig_line_q}; // [RL10] [RL11]
        end else if (reg_addr == `REG_LINE_COUNT) begin
            reg_rdata <= {16'h0, line_cnt_q}; // [RL10] [RL11]
        end else if (reg_addr == `REG_BYTES_PER_LINE) begin
            reg_rdata <= `TRC_BYTES_PER_LINE; // [RL16]
        end else if (reg_addr == `REG_UPLOAD_LINE) begin
            reg_rdata <= {17'h0, up_line_q};
        end else if (reg_addr == `REG_UPLOAD_DATA) begin
            reg_rdata <= up_data; // [RL16]
        end else if (reg_addr == `REG_CONFIG) begin
            reg_rdata <= {hb_timeout_q, 15'h0, hb_mode_q};
        end else if (reg_addr == `REG_OBSERVER) begin
            reg_rdata <= {31'h0, observer_run};
        end else begin
            reg_rdata <= `RST_WORD;
        end
    end
endmodule

// ### sim/bus_trace_capture_monitor.sv
// port checker for the trace capture block: register answers, observer enable
// assumes one clock domain; bound to the top module from the bench
`include "trace_capture_params.svh"
module bus_trace_capture_monitor
    import trace_capture_pkg::*;
(
    input wire logic sys_clk, // sampling clock
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [31:0] reg_rdata, // read data
    input wire logic observer_run // observer enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire cmd_wr = reg_wr && reg_addr == `REG_COMMAND;
    wire obs_cmd = (cmd_wr && reg_wdata[3:2] != 2'b00) || (reg_wr && reg_addr == `REG_OBSERVER);
    sequence s_run_cmd;
        cmd_wr && reg_wdata[`CMD_TRACE_RUN];
    endsequence
    sequence s_status_rd;
        reg_rd && reg_addr == `REG_STATUS;
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read answer");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > `REG_OBSERVER |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_line_size: assert property (reg_rd && reg_addr == `REG_BYTES_PER_LINE |=> reg_rdata == `TRC_BYTES_PER_LINE)
        else $error("line size wrong");
    chk_status_spare: assert property (s_status_rd |=> reg_rdata[31:2] == 30'h0)
        else $error("unused status bits set");
    chk_run_clears: assert property (s_run_cmd ##1 !reg_wr ##1 s_status_rd |=> !reg_rdata[`STAT_STOPPED])
        else $error("stopped flag survives run");
    chk_ana_start: assert property (cmd_wr && reg_wdata[2] && !reg_wdata[3] |=> observer_run)
        else $error("observer not started");
    chk_ana_stop: assert property (cmd_wr && reg_wdata[3] |=> !observer_run)
        else $error("observer not stopped");
    chk_obs_hold: assert property (!obs_cmd |=> $stable(observer_run))
        else $error("observer enable moved without command");
endmodule

// ### sim/bus_agent_model.sv
// far-side stand-in: drives observed bus pins and observer state bits
// assumes the bench picks a fixed pin pattern; toggle_en pulses ad bit 0
module bus_agent_model
    import trace_capture_pkg::*;
#(
    parameter bus_pins_type PINS = '0,
    parameter observer_bits_type OBS = '0
)
(
    input wire logic sys_clk, // sampling clock
    input wire logic rst_n, // async reset, active low
    input wire logic toggle_en, // pulse ad bit 0, four clocks each level
    output bus_pins_type bus_pins, // observed pins
    output observer_bits_type observer_bits // phase code and flags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] beat_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_q <= 3'h0;
        end else begin
            beat_q <= beat_q + 3'h1;
        end
    end
    // four-clock levels so the input filter never swallows a change
    assign bus_pins = (toggle_en && beat_q[2]) ? PINS ^ 48'h0000_0001_0000 : PINS;
    assign observer_bits = OBS;
endmodule

// ### sim/tb_bus_trace_capture.sv
// bench for the trace capture block: register tasks and one task per scenario
// assumes the agent model holds pins steady unless toggling is asked for
`include "trace_capture_params.svh"
module tb_bus_trace_capture
    import trace_capture_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam bus_pins_type PINS = 48'h1357_9BDF_2468;
    localparam observer_bits_type OBS = 7'b101_1010;
    localparam logic [6:0] OBS_LINE = {OBS[0], OBS[1], OBS[2], OBS[3], OBS[6:4]};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic toggle_en = 1'b0;
    logic [31:0] reg_rdata;
    logic observer_run;
    bus_pins_type bus_pins;
    observer_bits_type observer_bits;
    int failures = 0;
    int n_compared = 0;
    logic [31:0] v;
    logic [31:0] w;

    bus_trace_capture i_dut(.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_pins(bus_pins), .observer_bits(observer_bits), .observer_run(observer_run));
    bus_agent_model #(.PINS(PINS), .OBS(OBS)) i_agent(.sys_clk(sys_clk), .rst_n(rst_n),
        .toggle_en(toggle_en), .bus_pins(bus_pins), .observer_bits(observer_bits));

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic t_reset();
        wr(`REG_STATUS, 32'hFFFF_FFFF);
        rd(`REG_STATUS, v);
        check(v, 32'h0000_0000);
        rd(`REG_BYTES_PER_LINE, v);
        check(v, `TRC_BYTES_PER_LINE);
        rd(8'h80, v);
        check(v, 32'h0000_0000);
    endtask

    task automatic t_upload(input logic [14:0] line, input logic [8:0] hi);
        wr(`REG_UPLOAD_LINE, {17'h0, line});
        rd(`REG_UPLOAD_DATA, w);
        check(w, PINS[31:0]);
        rd(`REG_UPLOAD_DATA, w);
        check(w, {7'h0, hi, PINS[47:32]});
        rd(`REG_UPLOAD_DATA, w);
        check(w, 32'h0000_0000);
    endtask

    // default patterns match everything, so the first line triggers
    task automatic t_full_run();
        v = 32'h0;
        wr(`REG_COMMAND, 32'h0000_0004);
        @(posedge sys_clk);
        #1;
        check({31'h0, observer_run}, 32'h1);
        for (int i = 0; i < 12000 && v[0] !== 1'b1; i++) begin
            rd(`REG_STATUS, v);
        end
        check(v, 32'h0000_0003);
        wr(`REG_COMMAND, 32'h0000_0008);
        @(posedge sys_clk);
        #1;
        check({31'h0, observer_run}, 32'h0);
        rd(`REG_STATUS, v);
        check(v, 32'h0000_0003);
        rd(`REG_TRIG_LINE, v); // host reads only once stopped
        check(v, 32'h0000_0000);
        rd(`REG_LINE_COUNT, v);
        check(v, 32'h0000_4002);
        t_upload(15'h0, {2'b11, OBS_LINE});
        t_upload(15'h1, {2'b01, OBS_LINE});
    endtask

    // store only while ad bit 0 is high, trigger never matches
    task automatic t_gap();
        int n;
        n = 0;
        wr(`REG_TRIG_VAL_LO, 32'h0000_0001);
        wr(`REG_TRIG_CARE_LO, 32'h0000_0001);
        wr(`REG_SQ_VAL_LO, 32'h0001_0000);
        wr(`REG_SQ_CARE_LO, 32'h0001_0000);
        toggle_en <= 1'b1;
        wr(`REG_COMMAND, 32'h0000_0001);
        rd(`REG_STATUS, v);
        check(v, 32'h0000_0000);
        repeat (60) @(posedge sys_clk);
        wr(`REG_COMMAND, 32'h0000_0002);
        toggle_en <= 1'b0;
        rd(`REG_STATUS, v);
        check(v, 32'h0000_0001);
        rd(`REG_LINE_COUNT, v);
        wr(`REG_COMMAND, 32'h0000_0002);
        rd(`REG_LINE_COUNT, w);
        check(w, v);
        wr(`REG_UPLOAD_LINE, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            rd(`REG_UPLOAD_DATA, w);
            check(w, PINS[31:0]);
            rd(`REG_UPLOAD_DATA, w);
            if (i == 0) begin
                check({30'h0, w[24:23]}, 32'h1);
            end else begin
                n += int'(!w[23]);
            end
            rd(`REG_UPLOAD_DATA, w);
        end
        check({31'h0, n >= 1 && n <= 2}, 32'h1);
    endtask

    // timeout 1 means 256 clocks without the expected event
    task automatic t_heartbeat();
        wr(`REG_CONFIG, 32'h0001_0001);
        wr(`REG_COMMAND, 32'h0000_0001);
        repeat (200) @(posedge sys_clk);
        rd(`REG_STATUS, v);
        check({31'h0, v[1]}, 32'h0);
        repeat (100) @(posedge sys_clk);
        rd(`REG_STATUS, v);
        check({31'h0, v[1]}, 32'h1);
        wr(`REG_COMMAND, 32'h0000_0002);
    endtask

    task automatic finish_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_full_run();
        t_gap();
        t_heartbeat();
        finish_test();
    end

    // full run needs about 16.4k clocks, the rest a few hundred
    initial begin
        repeat (80000) @(posedge sys_clk);
        failures++;
        finish_test();
    end
endmodule

bind bus_trace_capture bus_trace_capture_monitor i_mon(.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .observer_run(observer_run));
